// ---- rtl/vdis_delay_tap.sv ----
// Purpose: Delay element fed by the lightly loaded row strobe copy.
// Assumes: i_ras comes from a register of the sequencer on the same clock.
// Notes:   Steers the column address switch and ends the transfer enable.
`timescale 1ns/1ps
module vdis_delay_tap
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Light row strobe copy
  input  wire logic i_ras,
  // Timed outputs
  output logic      o_mux_col,
  output logic      o_tr_active
);

  typedef struct packed {
    logic [1:0] cnt;
  } vdis_tap_type;

  vdis_tap_type s_r;
  vdis_tap_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (i_ras)
    begin
      if (s_r.cnt != vdis_pkg::DLY_CNT_MAX)
      begin
        s_nxt.cnt = s_r.cnt + 2'h1;
      end
    end
    else
    begin
      s_nxt.cnt = 2'h0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // The switch follows the light copy, not the loaded array strobes.
  assign o_mux_col   = i_ras;
  // Transfer enable spans the delay window from the strobe edge.
  assign o_tr_active = i_ras && (s_r.cnt < vdis_pkg::XFER_CYC_W);

endmodule

// ---- rtl/vdis_pkg.sv ----
// Purpose: Shared constants and types for the interleaved video-memory sequencer.
// Assumes: One 20 MHz clock shared with the processor buses.
// Notes:   Strobes toward the memory array are active low, responses active high.
package vdis_pkg;

  // Clock period and transfer-enable window.
  localparam int CLK_PERIOD_NS = 50;
  localparam int XFER_MIN_NS   = 90;
  localparam int XFER_MAX_NS   = 100;
  // Least time rounds up to whole cycles.
  localparam int XFER_CYC      = (XFER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] XFER_CYC_W   = 2'(XFER_CYC);
  localparam logic [1:0] DLY_CNT_MAX  = 2'h3;
  localparam logic [1:0] RAS_HOLD_CYC = 2'h3;
  localparam logic [1:0] BANK0_SCLK   = 2'h1;

  // One-hot sequencer states.
  typedef enum logic [11:0] {
    ST_IDLE  = 12'h001,
    ST_DROW  = 12'h002,
    ST_DCOL  = 12'h004,
    ST_DACC  = 12'h008,
    ST_DDONE = 12'h010,
    ST_WWAIT = 12'h020,
    ST_PC1   = 12'h040,
    ST_PRE2  = 12'h080,
    ST_XROW  = 12'h100,
    ST_XSET  = 12'h200,
    ST_XEND  = 12'h400,
    ST_BURST = 12'h800
  } vdis_seq_type;

  // Decoded request from the processor side.
  typedef struct packed {
    logic valid;
    logic instr;
    logic write;
    logic sel;
    logic addr2;
  } vdis_req_type;

  // Memory array side outputs.
  typedef struct packed {
    logic [1:0] ras_n;
    logic       ras_light_n;
    logic [1:0] cas_n;
    logic       we_n;
    logic       tr_n;
    logic [1:0] sclk;
    logic       mux_col;
    logic       bank_sel;
  } vdis_mem_type;

  // Responses toward the processor.
  typedef struct packed {
    logic data_done;
    logic pipe_rel;
    logic instr_done;
  } vdis_resp_type;

endpackage

// ---- rtl/vdis_sequencer.sv ----
// Purpose: Cycle sequencer for a two-bank interleaved video-memory block.
// Assumes: Processor buses share i_mclk; requests arrive already decoded.
// Notes:   Refresh and byte-lane write decode live outside this block.
// Operation
// - Load the row strobe at decode end only when this block is selected.
// - Row strobe at row cycle start, then switch mux to column address.
// - Mux switch follows the light strobe copy with no delay; the delay only times transfer enable.
// - Responses to the processor are valid in every clock cycle.
// - A data read takes five cycles: decode, row, column-strobe access.
// - A read decoded in the second precharge state takes six cycles.
// - Read ready comes no earlier than two cycles after the column strobe state.
// - Write ready comes two or three cycles after decode.
// - Write data latched at column strobe; ready after data hold only in the second variant.
// - First vendor variant: write ready inside the column strobe cycle.
// - Second vendor variant: write ready held to the following wait state.
// - A write decoded during the wait state takes at most six cycles.
// - A read decoded during write precharge takes at most eight cycles.
// - First instruction access takes six cycles: decode, transfer, first burst.
// - First instruction access at most nine after write, seven after read.
// - Three cycles separate row strobe from first serial shift clock edge.
// - Transfer enable lasts the delay window, then drops before shift clock.
// - Serial shift clock is combinational from registered state.
// - Each burst instruction is valid one cycle after its shift clock rises.
// - Banks alternate two-cycle bursts, one instruction per cycle overall.
// - Row strobe stays active three cycles once asserted.
// - Pipeline release is given in the column strobe state of a read.
`timescale 1ns/1ps
module vdis_sequencer
(
  // Clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst,
  // Processor request and burst continuation
  input  vdis_pkg::vdis_req_type       i_req,
  input  wire logic                    i_ibreq,
  // Static vendor strap, high for the second variant
  input  wire logic                    i_vendor_b,
  // Memory array
  output vdis_pkg::vdis_mem_type       o_mem,
  // Processor responses
  output vdis_pkg::vdis_resp_type      o_resp
);

  typedef struct packed {
    vdis_pkg::vdis_seq_type seq;
    vdis_pkg::vdis_req_type pend;
    logic                   pend_early;
    logic [1:0]             ras_cnt;
    logic                   xfer;
    logic                   first;
    logic                   bank;
    logic                   we;
    logic                   addr2;
    logic                   vend_meta;
    logic                   vend_b;
  } vdis_ctl_type;

  vdis_ctl_type           s_r;
  vdis_ctl_type           s_nxt;
  vdis_pkg::vdis_req_type go_req;
  logic                   accept;
  logic                   go;
  logic                   can_latch;
  logic                   ras;
  logic                   cas_act;
  logic                   mux_col;
  logic                   tr_active;
  logic                   in_prech;

  assign ras     = (s_r.ras_cnt != 2'h0);
  assign accept  = i_req.valid && i_req.sel;
  assign go_req  = s_r.pend.valid ? s_r.pend : i_req;
  // A request seen in the second precharge state waits one more cycle in idle.
  assign go      = ((s_r.seq == vdis_pkg::ST_IDLE) && (s_r.pend.valid || accept)) ||
                   ((s_r.seq == vdis_pkg::ST_PRE2) && s_r.pend.valid && s_r.pend_early);
  // Addresses arriving after the column strobe state, while precharging or during a burst, are held here.
  assign can_latch = (s_r.seq == vdis_pkg::ST_DACC) || (s_r.seq == vdis_pkg::ST_DDONE) ||
                     (s_r.seq == vdis_pkg::ST_WWAIT) || (s_r.seq == vdis_pkg::ST_PC1) ||
                     (s_r.seq == vdis_pkg::ST_PRE2) || (s_r.seq == vdis_pkg::ST_BURST);
  // The array is precharging after a data access, so a new request has to queue.
  assign in_prech  = (s_r.seq == vdis_pkg::ST_WWAIT) || (s_r.seq == vdis_pkg::ST_PC1) ||
                     (s_r.seq == vdis_pkg::ST_PRE2);

  always_comb
  begin
    s_nxt = s_r;
    // The strap is a pin, so it passes two stages before use.
    s_nxt.vend_meta = i_vendor_b;
    s_nxt.vend_b    = s_r.vend_meta;
    if (s_r.ras_cnt != 2'h0)
    begin
      s_nxt.ras_cnt = s_r.ras_cnt - 2'h1;
    end
    if (can_latch && accept && !s_r.pend.valid)
    begin
      s_nxt.pend       = i_req;
      s_nxt.pend_early = (s_r.seq != vdis_pkg::ST_PRE2);
    end
    if (go)
    begin
      s_nxt.ras_cnt    = vdis_pkg::RAS_HOLD_CYC;
      s_nxt.xfer       = go_req.instr;
      s_nxt.we         = go_req.write && !go_req.instr;
      s_nxt.addr2      = go_req.addr2;
      s_nxt.pend.valid = 1'b0;
      s_nxt.seq        = go_req.instr ? vdis_pkg::ST_XROW : vdis_pkg::ST_DROW;
    end
    else
    begin
      case (s_r.seq)
        vdis_pkg::ST_IDLE:
        begin
          s_nxt.seq = vdis_pkg::ST_IDLE;
        end
        vdis_pkg::ST_DROW:
        begin
          s_nxt.seq = vdis_pkg::ST_DCOL;
        end
        vdis_pkg::ST_DCOL:
        begin
          s_nxt.seq = s_r.we ? vdis_pkg::ST_WWAIT : vdis_pkg::ST_DACC;
        end
        vdis_pkg::ST_DACC:
        begin
          s_nxt.seq = vdis_pkg::ST_DDONE;
        end
        vdis_pkg::ST_DDONE:
        begin
          s_nxt.seq = vdis_pkg::ST_PRE2;
        end
        vdis_pkg::ST_WWAIT:
        begin
          s_nxt.seq = vdis_pkg::ST_PC1;
        end
        vdis_pkg::ST_PC1:
        begin
          s_nxt.seq = vdis_pkg::ST_PRE2;
        end
        vdis_pkg::ST_PRE2:
        begin
          s_nxt.seq = vdis_pkg::ST_IDLE;
        end
        vdis_pkg::ST_XROW:
        begin
          s_nxt.seq = vdis_pkg::ST_XSET;
        end
        vdis_pkg::ST_XSET:
        begin
          s_nxt.seq = vdis_pkg::ST_XEND;
        end
        vdis_pkg::ST_XEND:
        begin
          s_nxt.seq   = vdis_pkg::ST_BURST;
          s_nxt.first = 1'b1;
          s_nxt.bank  = 1'b0;
        end
        vdis_pkg::ST_BURST:
        begin
          // Each bank gets two cycles; toggling every cycle interleaves them.
          s_nxt.first = 1'b0;
          s_nxt.bank  = ~s_r.bank;
          if (!s_r.first && !i_ibreq)
          begin
            s_nxt.seq = vdis_pkg::ST_IDLE;
          end
        end
        default:
        begin
          s_nxt.seq = vdis_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r     <= '0;
      s_r.seq <= vdis_pkg::ST_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  vdis_delay_tap u_tap
  (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_ras       (ras),
    .o_mux_col   (mux_col),
    .o_tr_active (tr_active)
  );

  // No column strobe during a row transfer; the serial port needs none.
  // A read keeps the column strobe on until its data has been taken.
  assign cas_act = (s_r.seq == vdis_pkg::ST_DCOL) ||
                   (!s_r.we && ((s_r.seq == vdis_pkg::ST_DACC) || (s_r.seq == vdis_pkg::ST_DDONE)));

  always_comb
  begin
    o_mem.ras_n       = {2{~ras}};
    o_mem.ras_light_n = ~ras;
    // Writes strobe only the bank that address bit two selects.
    o_mem.cas_n[0]    = ~(cas_act && (!s_r.we || !s_r.addr2));
    o_mem.cas_n[1]    = ~(cas_act && (!s_r.we || s_r.addr2));
    // Write enable is set up ahead of the column strobe edge that latches data.
    o_mem.we_n        = ~(s_r.we && ((s_r.seq == vdis_pkg::ST_DROW) || (s_r.seq == vdis_pkg::ST_DCOL)));
    o_mem.tr_n        = ~(s_r.xfer && tr_active);
    o_mem.sclk[0]     = (s_r.seq == vdis_pkg::ST_BURST) && !s_r.bank;
    o_mem.sclk[1]     = (s_r.seq == vdis_pkg::ST_BURST) && s_r.bank;
    o_mem.mux_col     = mux_col;
    o_mem.bank_sel    = s_r.bank;
  end

  // Responses are decoded from registers so they are defined every cycle.
  always_comb
  begin
    o_resp.data_done  = ((s_r.seq == vdis_pkg::ST_DDONE) && !s_r.we) ||
                        (s_r.we && (s_r.seq == vdis_pkg::ST_DCOL) && !s_r.vend_b) ||
                        (s_r.we && (s_r.seq == vdis_pkg::ST_WWAIT) && s_r.vend_b);
    o_resp.pipe_rel   = (s_r.seq == vdis_pkg::ST_DCOL) && !s_r.we;
    o_resp.instr_done = (s_r.seq == vdis_pkg::ST_BURST) && !s_r.first;
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  sequence seq_read_go;
    go && !go_req.instr && !go_req.write;
  endsequence

  sequence seq_read_tail;
    o_resp.pipe_rel ##1 !o_resp.data_done ##1 o_resp.data_done;
  endsequence

  sequence seq_write_go;
    go && go_req.write && !go_req.instr;
  endsequence

  sequence seq_instr_go;
    go && go_req.instr;
  endsequence

  chk_read_access: assert property (seq_read_go |=> ras ##1 seq_read_tail)
    else $error("read did not finish in five cycles");
  chk_unsel_quiet: assert property ((s_r.seq == vdis_pkg::ST_IDLE) && !s_r.pend.valid &&
                                    i_req.valid && !i_req.sel |=> !ras)
    else $error("row strobe loaded for unselected address");
  chk_write_early: assert property (seq_write_go ##0 !s_r.vend_b |=> ##1 o_resp.data_done)
    else $error("first variant write ready not in column cycle");
  chk_write_late: assert property (seq_write_go ##0 s_r.vend_b |=> ##1 !o_resp.data_done ##1 o_resp.data_done)
    else $error("second variant write ready not in wait state");
  chk_ras_width: assert property ($rose(ras) |-> ras[*3] ##1 !ras)
    else $error("row strobe width not three cycles");
  chk_mux_switch: assert property ($rose(ras) |-> o_mem.mux_col && !o_mem.ras_light_n)
    else $error("mux did not switch in row cycle");
  chk_instr_first: assert property (seq_instr_go |=> ras ##3 (o_mem.sclk == vdis_pkg::BANK0_SCLK)
                                    ##1 o_resp.instr_done)
    else $error("initial instruction access timing wrong");
  chk_tr_window: assert property ($fell(o_mem.tr_n) |-> (!o_mem.tr_n)[*2] ##1 o_mem.tr_n
                                  ##1 (o_mem.sclk != 2'h0))
    else $error("transfer enable window wrong");
  chk_burst_alt: assert property ((s_r.seq == vdis_pkg::ST_BURST) && !s_r.first && i_ibreq |=>
                                  (o_mem.sclk != $past(o_mem.sclk)) && o_resp.instr_done)
    else $error("banks did not alternate");
  chk_prech_delay: assert property ((s_r.seq == vdis_pkg::ST_PRE2) && !s_r.pend.valid && accept |=>
                                    !ras ##1 ras)
    else $error("access from second precharge not delayed");

  // Row strobe start and its light copy.
  chk_row_start: assert property (go |=> (o_mem.ras_n == 2'h0) && o_mem.mux_col)
    else $error("row strobe not started after decode");
  chk_light_copy: assert property (o_mem.ras_light_n == o_mem.ras_n[0])
    else $error("light row strobe copy differs");

  // Read ready is held back until the data has crossed the transceivers.
  chk_read_ready: assert property (o_resp.data_done && !s_r.we |->
                                   ($past(s_r.seq, 2) == vdis_pkg::ST_DCOL))
    else $error("read ready too early after column strobe");
  chk_pipe_lead: assert property (o_resp.pipe_rel |-> ##2 o_resp.data_done)
    else $error("pipeline release not two cycles before ready");

  // Write data is latched by the column strobe; ready never runs ahead of it.
  chk_write_strobe: assert property (s_r.we && (s_r.seq == vdis_pkg::ST_DCOL) |->
                                     !o_mem.we_n && (o_mem.cas_n != 2'h3))
    else $error("write column strobe or enable missing");
  chk_write_ready: assert property (o_resp.data_done && s_r.we |-> (s_r.seq == vdis_pkg::ST_DCOL) ||
                                    ($past(s_r.seq) == vdis_pkg::ST_DCOL))
    else $error("write ready outside column or wait cycle");

  // Responses stay defined and quiet whenever the block is idle.
  chk_resp_idle: assert property ((s_r.seq == vdis_pkg::ST_IDLE) |-> (o_resp == 3'h0))
    else $error("response active while idle");

  // Shift clocks only run in the burst, and transfer enable is gone by then.
  chk_sclk_rest: assert property ((s_r.seq != vdis_pkg::ST_BURST) |-> (o_mem.sclk == 2'h0))
    else $error("shift clock outside burst");
  chk_tr_off: assert property ((o_mem.sclk != 2'h0) |-> o_mem.tr_n)
    else $error("transfer enable overlaps shift clock");
  chk_burst_first: assert property ((s_r.seq == vdis_pkg::ST_BURST) && s_r.first |->
                                    (o_mem.sclk == vdis_pkg::BANK0_SCLK) ##1 o_resp.instr_done)
    else $error("first burst instruction late");
  chk_bank_track: assert property ((s_r.seq == vdis_pkg::ST_BURST) |-> (o_mem.sclk[1] == o_mem.bank_sel))
    else $error("bank select does not follow shift clock");

  // Requests that queue behind a precharge still finish within their bound.
  sequence seq_queued_req;
    in_prech && accept && !s_r.pend.valid;
  endsequence

  chk_write_queue: assert property (seq_queued_req ##0 (i_req.write && !i_req.instr) |->
                                    ##[1:5] o_resp.data_done)
    else $error("queued write longer than six cycles");
  chk_read_queue: assert property (seq_queued_req ##0 !(i_req.write || i_req.instr) |->
                                   ##[1:7] o_resp.data_done)
    else $error("queued read longer than eight cycles");
  chk_instr_queue: assert property (seq_queued_req ##0 i_req.instr |->
                                    ##[1:8] o_resp.instr_done)
    else $error("queued instruction access longer than nine cycles");

endmodule

// ---- testbench/vdis_cpu_model.sv ----
// Purpose: Processor-side model that issues decoded requests and times the answers.
// Assumes: Requests change and answers are sampled 1 ns after each rising edge.
// Notes:   Cycle 0 is the decode cycle; results are left in the t_ and n_ variables.
`timescale 1ns/1ps
module vdis_cpu_model
(
  // Clock
  input  wire logic               i_mclk,
  // Block outputs
  input  vdis_pkg::vdis_mem_type  i_mem,
  input  vdis_pkg::vdis_resp_type i_resp,
  // Request lines toward the block
  output vdis_pkg::vdis_req_type  o_req,
  output logic                    o_ibreq
);
  int   t_done;
  int   t_pipe;
  int   t_sclk;
  int   t_cas;
  int   n_ras;
  int   n_tr;
  int   n_alt;
  int   n_bad;
  logic col1;

  initial
  begin
    o_req   = '0;
    o_ibreq = 1'b0;
  end

  // A data access returns at its answer so a follow-up can land in the precharge states.
  task automatic access(input int gap, input logic ins, input logic wr, input logic sel,
                        input int burst, input int lim);
    logic [1:0] exp_clk;
    t_done = -1;
    t_pipe = -1;
    t_sclk = -1;
    t_cas  = -1;
    n_ras  = 0;
    n_tr   = 0;
    n_alt  = 0;
    n_bad  = 0;
    repeat (gap) @(posedge i_mclk);
    #1;
    o_req   = '{1'b1, ins, wr, sel, 1'b0};
    o_ibreq = ins;
    for (int k = 1; k <= lim; k++)
    begin
      @(posedge i_mclk);
      #1;
      o_req = '0;
      if (k == 1) col1 = i_mem.mux_col;
      if (t_done < 0 && (i_resp.data_done === 1'b1 || i_resp.instr_done === 1'b1)) t_done = k;
      if (t_pipe < 0 && i_resp.pipe_rel === 1'b1) t_pipe = k;
      if (t_sclk < 0 && i_mem.sclk[0] === 1'b1) t_sclk = k;
      if (t_cas < 0 && i_mem.cas_n !== 2'h3) t_cas = k;
      n_ras += int'(i_mem.ras_n === 2'h0);
      n_tr  += int'(i_mem.tr_n === 1'b0);
      n_bad += int'($isunknown(i_resp));
      if (t_sclk > 0 && k < t_sclk + burst)
      begin
        exp_clk = ((k - t_sclk) % 2 == 1) ? 2'h2 : 2'h1;
        n_alt += int'(i_mem.sclk === exp_clk && (k == t_sclk || i_resp.instr_done === 1'b1));
        if (k == t_sclk + burst - 1)
        begin
          o_ibreq = 1'b0;
          break;
        end
      end
      if (!ins && t_done > 0) break;
    end
  endtask
endmodule

// ---- testbench/vdis_sequencer_tb.sv ----
// Purpose: Self-checking bench for the interleaved video-memory sequencer.
// Assumes: 20 MHz clock; every input changes 1 ns after a rising edge.
// Notes:   Every access is bounded, so a silent block shows as a wrong cycle count.
`timescale 1ns/1ps
module vdis_sequencer_tb;
  logic                    i_mclk;
  logic                    i_rst;
  logic                    i_vendor_b;
  logic                    i_ibreq;
  vdis_pkg::vdis_req_type  i_req;
  vdis_pkg::vdis_mem_type  mem;
  vdis_pkg::vdis_resp_type resp;
  int                      err_count = 0;
  int                      check_count = 0;

  initial
  begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  vdis_sequencer u_vdis_sequencer
  (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_req      (i_req),
    .i_ibreq    (i_ibreq),
    .i_vendor_b (i_vendor_b),
    .o_mem      (mem),
    .o_resp     (resp)
  );

  vdis_cpu_model u_vdis_cpu_model
  (
    .i_mclk  (i_mclk),
    .i_mem   (mem),
    .i_resp  (resp),
    .o_req   (i_req),
    .o_ibreq (i_ibreq)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t %s: saw %0d expected %0d", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic t_read();
    u_vdis_cpu_model.access(6, 1'b0, 1'b0, 1'b1, 0, 12);
    check(u_vdis_cpu_model.t_done, 4, "read ready");
    check(u_vdis_cpu_model.t_pipe, 2, "pipeline release");
    check(u_vdis_cpu_model.n_ras, 3, "row strobe width");
    check(u_vdis_cpu_model.col1, 1, "column mux");
    check(u_vdis_cpu_model.n_bad, 0, "responses known");
    $display("test read done");
  endtask

  task automatic t_unsel();
    u_vdis_cpu_model.access(6, 1'b0, 1'b0, 1'b0, 0, 8);
    check(u_vdis_cpu_model.t_done, 32'hFFFFFFFF, "unselected answer");
    check(u_vdis_cpu_model.n_ras, 0, "unselected strobe");
    $display("test unselected done");
  endtask

  task automatic t_write();
    for (int v = 0; v < 2; v++)
    begin
      i_vendor_b = v[0];
      u_vdis_cpu_model.access(6, 1'b0, 1'b1, 1'b1, 0, 10);
      check(u_vdis_cpu_model.t_done, 2 + v, "write ready");
      check(u_vdis_cpu_model.t_cas, 2, "write column strobe");
    end
    i_vendor_b = 1'b0;
    $display("test write done");
  endtask

  task automatic t_instr();
    u_vdis_cpu_model.access(6, 1'b1, 1'b0, 1'b1, 4, 16);
    check(u_vdis_cpu_model.t_done, 5, "first instruction");
    check(u_vdis_cpu_model.t_sclk, 4, "first shift clock");
    check(u_vdis_cpu_model.n_tr, 2, "transfer enable");
    check(u_vdis_cpu_model.n_alt, 4, "bank alternation");
    check(u_vdis_cpu_model.n_ras, 3, "transfer row strobe");
    $display("test instruction done");
  endtask

  // Columns: first instr, first write, gap, second instr, second write, low, high.
  task automatic t_follow();
    int c [6][7] = '{'{0, 0, 1, 0, 0, 5, 5}, '{0, 1, 1, 0, 1, 1, 5}, '{0, 1, 2, 0, 0, 1, 7},
                     '{0, 1, 2, 1, 0, 1, 8}, '{0, 0, 1, 1, 0, 1, 6}, '{0, 1, 1, 0, 1, 1, 6}};
    for (int i = 0; i < 6; i++)
    begin
      u_vdis_cpu_model.access(6, c[i][0][0], c[i][1][0], 1'b1, 0, 12);
      u_vdis_cpu_model.access(c[i][2], c[i][3][0], c[i][4][0], 1'b1, 2, 16);
      check(32'(u_vdis_cpu_model.t_done >= c[i][5] && u_vdis_cpu_model.t_done <= c[i][6]), 1,
            "follow-up length");
    end
    $display("test follow-up done");
  endtask

  initial
  begin
    i_rst      = 1'b1;
    i_vendor_b = 1'b0;
    repeat (10) @(posedge i_mclk);
    #1;
    i_rst = 1'b0;
    t_read();
    t_unsel();
    t_write();
    t_instr();
    t_follow();
    give_verdict();
  end
endmodule
